// [verilog/hcr_defs.vh]
// hcr_defs.vh: offsets, reset values and timing counts of the hub configuration bank
`ifndef HCR_DEFS_VH
`define HCR_DEFS_VH
`define HCR_OFS_VENDOR_LOW 8'h00
`define HCR_OFS_VENDOR_HIGH 8'h01
`define HCR_OFS_PRODUCT_LOW 8'h02
`define HCR_OFS_PRODUCT_HIGH 8'h03
`define HCR_OFS_RELEASE_LOW 8'h04
`define HCR_OFS_RELEASE_HIGH 8'h05
`define HCR_OFS_PRODUCT_TEXT 8'h54
`define HCR_OFS_PRODUCT_TEXT_END 8'h91
`define HCR_OFS_SERIAL_TEXT 8'h92
`define HCR_OFS_SERIAL_TEXT_END 8'hCF
`define HCR_OFS_CHARGING_ENABLE 8'hD0
`define HCR_OFS_RESERVED_E0 8'hE0
`define HCR_OFS_RESERVED_F5 8'hF5
`define HCR_OFS_BOOST_UP 8'hF6
`define HCR_OFS_BOOST_UPPER 8'hF7
`define HCR_OFS_BOOST_LOWER 8'hF8
`define HCR_OFS_RESERVED_F9 8'hF9
`define HCR_OFS_PAIR_SWAP 8'hFA
`define HCR_OFS_MAP_12 8'hFB
`define HCR_OFS_MAP_34 8'hFC
`define HCR_OFS_MAP_56 8'hFD
`define HCR_OFS_MAP_7 8'hFE
`define HCR_OFS_STATUS_COMMAND 8'hFF
`define HCR_RESET_VALUE 8'h00
`define HCR_LAST_LOAD_OFS 8'hFE
`define HCR_LOAD_LAT 2'h2
`endif

// [verilog/hcr_byte_mem.v]
// hcr_byte_mem.v: 256 x 8 register store, registered read, clear sweep after reset
`default_nettype none
module hcr_byte_mem #(
    parameter AW = 8,
    parameter DW = 8
) (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata,
    output reg clear_done
);
    // =====================================================
    // storage
    reg [DW-1:0] mem [0:(1<<AW)-1];
    reg [AW-1:0] clr_ptr;

    // clear sweep zeroes every byte before first use
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clr_ptr <= {AW{1'b0}};
            clear_done <= 1'b0;
        end else if (ce && !clear_done) begin
            clr_ptr <= clr_ptr + {{(AW-1){1'b0}}, 1'b1};
            if (clr_ptr == {AW{1'b1}}) begin
                clear_done <= 1'b1;
            end
        end
    end

    always @(posedge clk) begin
        if (ce) begin
            if (!clear_done) begin
                mem[clr_ptr] <= {DW{1'b0}};
            end else if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule // hcr_byte_mem
`default_nettype wire

// [verilog/hcr_config_bank.v]
// hcr_config_bank.v: hub configuration register bank, host port and eeprom loader
//
// Behaviour
// RL1: offset 00h holds vendor identifier low byte, reported for enumeration.
// RL2: offset 01h holds vendor identifier high byte, joined with low byte.
// RL3: offset 02h holds product identifier low byte.
// RL4: offset 03h holds product identifier high byte.
// RL5: offsets 04h and 05h hold the BCD release number.
// RL6: identifiers load from host writes or from the eeprom read.
// RL7: status/command at FFh is host only, never eeprom loaded, resets zero.
// RL8: every register reads and writes and resets to zero.
// RL9: outside party writes zero to reserved bytes and ignores their reads.
// RL10: eeprom path only reads, applies whatever it gets, then allows attach.
// RL11: byte offsets in a 256-entry space, one byte per access.
`default_nettype none
`include "hcr_defs.vh"
module hcr_config_bank #(
    parameter AW = 8,
    parameter DW = 8
) (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire eeprom_mode,
    input wire host_req,
    input wire host_wr,
    input wire [AW-1:0] host_addr,
    input wire [DW-1:0] host_wdata,
    output wire host_ack,
    output reg [DW-1:0] host_rdata,
    output reg host_rvalid,
    output reg ee_req,
    output reg [AW-1:0] ee_addr,
    input wire ee_ack,
    input wire [DW-1:0] ee_data,
    output reg config_done,
    output reg [15:0] vendor_code,
    output reg [15:0] product_code,
    output reg [15:0] release_number,
    output reg [DW-1:0] charging_port_enable,
    output reg [DW-1:0] upstream_drive_boost,
    output reg [DW-1:0] upper_ports_drive_boost,
    output reg [DW-1:0] lower_ports_drive_boost,
    output reg [DW-1:0] pair_polarity_swap,
    output reg [DW-1:0] logical_map_ports_1_2,
    output reg [DW-1:0] logical_map_ports_3_4,
    output reg [DW-1:0] logical_map_ports_5_6,
    output reg [DW-1:0] logical_map_port_7,
    output reg [DW-1:0] host_status_command
);
    // =====================================================
    // loader states
    localparam ST_CLEAR = 2'b00;
    localparam ST_STRAP = 2'b01;
    localparam ST_LOAD = 2'b10;
    localparam ST_RUN = 2'b11;

    reg [1:0] state;
    reg [1:0] next_state;
    reg mode_s1;
    reg mode_s2;
    reg rd_pend;
    wire clear_done;
    wire wr_vendor_low;
    wire wr_vendor_high;
    wire wr_product_low;
    wire wr_product_high;
    wire wr_release_low;
    wire wr_release_high;
    wire wr_charging;
    wire wr_boost_up;
    wire wr_boost_upper;
    wire wr_boost_lower;
    wire wr_pair_swap;
    wire wr_map_12;
    wire wr_map_34;
    wire wr_map_56;
    wire wr_map_7;
    wire wr_status;
    wire [DW-1:0] mem_rdata;
    reg mem_we;
    reg [AW-1:0] mem_waddr;
    reg [DW-1:0] mem_wdata;

    // =====================================================
    // offset decode shared by write path
    function is_ofs;
        input [AW-1:0] a;
        input [7:0] o;
        begin
            is_ofs = (a == o[AW-1:0]);
        end
    endfunction

    // =====================================================
    // strap sync
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_s1 <= 1'b0;
            mode_s2 <= 1'b0;
        end else if (ce) begin
            mode_s1 <= eeprom_mode;
            mode_s2 <= mode_s1;
        end
    end

    // =====================================================
    // state machine
    always @* begin
        next_state = state;
        case (state)
            ST_CLEAR: begin
                if (clear_done) begin
                    next_state = ST_STRAP;
                end
            end
            ST_STRAP: begin
                next_state = mode_s2 ? ST_LOAD : ST_RUN;
            end
            ST_LOAD: begin
                if (ee_ack && ee_addr == `HCR_LAST_LOAD_OFS) begin
                    next_state = ST_RUN; // [RL10]
                end
            end
            ST_RUN: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_CLEAR;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_CLEAR;
            ee_req <= 1'b0;
            ee_addr <= {AW{1'b0}};
            config_done <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            if (state == ST_STRAP) begin
                ee_req <= mode_s2; // [RL6] [RL10]
            end
            if (state == ST_LOAD && ee_ack) begin
                // byte-at-a-time read only, status byte never fetched
                if (ee_addr == `HCR_LAST_LOAD_OFS) begin
                    ee_req <= 1'b0; // [RL7]
                end else begin
                    ee_addr <= ee_addr + {{(AW-1){1'b0}}, 1'b1}; // [RL11]
                end
            end
            config_done <= (next_state == ST_RUN); // [RL10]
        end
    end

    // =====================================================
    // write source select
    assign host_ack = host_req && (state == ST_RUN);

    always @* begin
        mem_we = 1'b0;
        mem_waddr = host_addr;
        mem_wdata = host_wdata;
        if (state == ST_LOAD && ee_ack) begin
            mem_we = 1'b1; // [RL6]
            mem_waddr = ee_addr;
            mem_wdata = ee_data; // [RL10]
        end else if (host_ack && host_wr) begin
            mem_we = 1'b1; // [RL11]
        end
    end

    hcr_byte_mem #(
        .AW(AW),
        .DW(DW)
    ) u_mem (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(host_addr),
        .rdata(mem_rdata),
        .clear_done(clear_done)
    );

    // =====================================================
    // host read return, two cycles after the request
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_pend <= 1'b0;
            host_rvalid <= 1'b0;
            host_rdata <= `HCR_RESET_VALUE;
        end else if (ce) begin
            rd_pend <= host_ack && !host_wr;
            host_rvalid <= rd_pend;
            if (rd_pend) begin
                host_rdata <= mem_rdata; // [RL8]
            end
        end
    end

    // =====================================================
    // shadow write strobes, one per copied offset
    assign wr_vendor_low = mem_we && is_ofs(mem_waddr, `HCR_OFS_VENDOR_LOW);
    assign wr_vendor_high = mem_we && is_ofs(mem_waddr, `HCR_OFS_VENDOR_HIGH);
    assign wr_product_low = mem_we && is_ofs(mem_waddr, `HCR_OFS_PRODUCT_LOW);
    assign wr_product_high = mem_we && is_ofs(mem_waddr, `HCR_OFS_PRODUCT_HIGH);
    assign wr_release_low = mem_we && is_ofs(mem_waddr, `HCR_OFS_RELEASE_LOW);
    assign wr_release_high = mem_we && is_ofs(mem_waddr, `HCR_OFS_RELEASE_HIGH);
    assign wr_charging = mem_we && is_ofs(mem_waddr, `HCR_OFS_CHARGING_ENABLE);
    assign wr_boost_up = mem_we && is_ofs(mem_waddr, `HCR_OFS_BOOST_UP);
    assign wr_boost_upper = mem_we && is_ofs(mem_waddr, `HCR_OFS_BOOST_UPPER);
    assign wr_boost_lower = mem_we && is_ofs(mem_waddr, `HCR_OFS_BOOST_LOWER);
    assign wr_pair_swap = mem_we && is_ofs(mem_waddr, `HCR_OFS_PAIR_SWAP);
    assign wr_map_12 = mem_we && is_ofs(mem_waddr, `HCR_OFS_MAP_12);
    assign wr_map_34 = mem_we && is_ofs(mem_waddr, `HCR_OFS_MAP_34);
    assign wr_map_56 = mem_we && is_ofs(mem_waddr, `HCR_OFS_MAP_56);
    assign wr_map_7 = mem_we && is_ofs(mem_waddr, `HCR_OFS_MAP_7);
    assign wr_status = mem_we && is_ofs(mem_waddr, `HCR_OFS_STATUS_COMMAND) && (state == ST_RUN);

    // =====================================================
    // identifier shadows, built from byte pairs
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vendor_code <= 16'h0000; // [RL8]
        end else if (ce) begin
            if (wr_vendor_low) begin
                vendor_code[7:0] <= mem_wdata; // [RL1]
            end
            if (wr_vendor_high) begin
                vendor_code[15:8] <= mem_wdata; // [RL2]
            end
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            product_code <= 16'h0000; // [RL8]
        end else if (ce) begin
            if (wr_product_low) begin
                product_code[7:0] <= mem_wdata; // [RL3]
            end
            if (wr_product_high) begin
                product_code[15:8] <= mem_wdata; // [RL4]
            end
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            release_number <= 16'h0000; // [RL8]
        end else if (ce) begin
            if (wr_release_low) begin
                release_number[7:0] <= mem_wdata; // [RL5]
            end
            if (wr_release_high) begin
                release_number[15:8] <= mem_wdata; // [RL5]
            end
        end
    end

    // =====================================================
    // byte shadows driving hub logic
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            charging_port_enable <= `HCR_RESET_VALUE; // [RL8]
        end else if (ce && wr_charging) begin
            charging_port_enable <= mem_wdata;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            upstream_drive_boost <= `HCR_RESET_VALUE;
        end else if (ce && wr_boost_up) begin
            upstream_drive_boost <= mem_wdata;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            upper_ports_drive_boost <= `HCR_RESET_VALUE;
        end else if (ce && wr_boost_upper) begin
            upper_ports_drive_boost <= mem_wdata;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lower_ports_drive_boost <= `HCR_RESET_VALUE;
        end else if (ce && wr_boost_lower) begin
            lower_ports_drive_boost <= mem_wdata;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pair_polarity_swap <= `HCR_RESET_VALUE;
        end else if (ce && wr_pair_swap) begin
            pair_polarity_swap <= mem_wdata;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            logical_map_ports_1_2 <= `HCR_RESET_VALUE;
        end else if (ce && wr_map_12) begin
            logical_map_ports_1_2 <= mem_wdata;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            logical_map_ports_3_4 <= `HCR_RESET_VALUE;
        end else if (ce && wr_map_34) begin
            logical_map_ports_3_4 <= mem_wdata;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            logical_map_ports_5_6 <= `HCR_RESET_VALUE;
        end else if (ce && wr_map_56) begin
            logical_map_ports_5_6 <= mem_wdata;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            logical_map_port_7 <= `HCR_RESET_VALUE;
        end else if (ce && wr_map_7) begin
            logical_map_port_7 <= mem_wdata;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            host_status_command <= `HCR_RESET_VALUE; // [RL7]
        end else if (ce && wr_status) begin
            host_status_command <= mem_wdata; // [RL7]
        end
    end
endmodule // hcr_config_bank
`default_nettype wire

// [test/hcr_config_bank_assertions.sv]
// hcr_config_bank_assertions.sv: port checks for the configuration bank
`default_nettype none
module hcr_config_bank_assertions (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic host_req,
    input wire logic host_wr,
    input wire logic host_ack,
    input wire logic host_rvalid,
    input wire logic ee_req,
    input wire logic [7:0] ee_addr,
    input wire logic ee_ack,
    input wire logic config_done,
    input wire logic [7:0] host_status_command
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_ack_after_done: assert property (host_ack |-> config_done && host_req)
        else $error("host ack outside run state");
    a_read_answer: assert property (host_ack && !host_wr |-> ##2 host_rvalid)
        else $error("read answer missing");
    a_rvalid_cause: assert property (host_rvalid |-> $past(host_ack && !host_wr, 2))
        else $error("read answer without read");
    a_ee_step: assert property (ee_req && ee_ack && ee_addr != 8'hFE
        |=> ee_req && ee_addr == $past(ee_addr) + 8'h01)
        else $error("eeprom offset did not step");
    a_ee_last_byte: assert property (ee_req && ee_ack && ee_addr == 8'hFE
        |=> !ee_req && config_done)
        else $error("load did not end after last byte");
    a_ee_hold_req: assert property (ee_req && !ee_ack |=> ee_req && $stable(ee_addr))
        else $error("eeprom request not held");
    a_ee_no_status: assert property (ee_req |-> ee_addr != 8'hFF && !config_done)
        else $error("status byte fetched from eeprom");
    a_done_holds: assert property (config_done |=> config_done)
        else $error("configured flag fell");
    a_status_reset: assert property ($rose(config_done) |-> host_status_command == 8'h00)
        else $error("status byte not zero after load");
endmodule // hcr_config_bank_assertions
bind hcr_config_bank hcr_config_bank_assertions hcr_config_bank_assertions_inst (.clk, .arst_n,
    .host_req, .host_wr, .host_ack, .host_rvalid, .ee_req, .ee_addr, .ee_ack, .config_done,
    .host_status_command);
`default_nettype wire

// [test/hcr_eeprom_model.sv]
// hcr_eeprom_model.sv: read-only configuration eeprom answering the loader
`default_nettype none
module hcr_eeprom_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic slow,
    input wire logic ee_req,
    input wire logic [7:0] ee_addr,
    output logic ee_ack,
    output logic [7:0] ee_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_cnt;
    logic [1:0] lag;
    assign lag = (slow && ee_addr[0]) ? 2'h2 : 2'h0;
    // =====================================================
    // one byte per request, content fixed, never written
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ee_ack <= 1'b0;
            ee_data <= 8'h00;
            wait_cnt <= 2'h0;
        end else if (ee_ack || !ee_req || wait_cnt < lag) begin
            ee_ack <= 1'b0;
            ee_data <= ~ee_data;
            wait_cnt <= (ee_ack || !ee_req) ? 2'h0 : wait_cnt + 2'h1;
        end else begin
            ee_ack <= 1'b1;
            ee_data <= ee_addr ^ 8'hA5;
        end
    end
endmodule // hcr_eeprom_model
`default_nettype wire

// [test/tb_top.sv]
// tb_top.sv: self-checking bench of the configuration bank
`default_nettype none
`include "hcr_defs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, arst_n = 0, eeprom_mode = 1, slow = 1;
    logic host_req = 0, host_wr = 0;
    logic [7:0] host_addr = 0, host_wdata = 0, q, a, d;
    wire host_ack, host_rvalid, ee_req, ee_ack, config_done;
    wire [7:0] host_rdata, ee_addr, ee_data, cpe, upb, uppb, lpb, pps, m12, m34, m56, m7, hsc;
    wire [15:0] vendor_code, product_code, release_number;
    int error_cnt = 0, tests_run = 0;
    always #10 clk = ~clk;
    hcr_config_bank hcr_config_bank_inst (.clk(clk), .arst_n(arst_n), .ce(1'b1),
        .eeprom_mode(eeprom_mode), .host_req(host_req), .host_wr(host_wr),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_ack(host_ack),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid), .ee_req(ee_req), .ee_addr(ee_addr),
        .ee_ack(ee_ack), .ee_data(ee_data), .config_done(config_done),
        .vendor_code(vendor_code), .product_code(product_code), .release_number(release_number),
        .charging_port_enable(cpe), .upstream_drive_boost(upb), .upper_ports_drive_boost(uppb),
        .lower_ports_drive_boost(lpb), .pair_polarity_swap(pps), .logical_map_ports_1_2(m12),
        .logical_map_ports_3_4(m34), .logical_map_ports_5_6(m56), .logical_map_port_7(m7),
        .host_status_command(hsc));
    hcr_eeprom_model hcr_eeprom_model_inst (.clk(clk), .arst_n(arst_n), .slow(slow),
        .ee_req(ee_req), .ee_addr(ee_addr), .ee_ack(ee_ack), .ee_data(ee_data));
    // =====================================================
    // helpers
    function automatic logic [7:0] rom(input logic [7:0] x);
        return x ^ 8'hA5;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic host(input logic wr, input logic [7:0] ad, input logic [7:0] wd);
        host_req <= 1'b1;
        host_wr <= wr;
        host_addr <= ad;
        host_wdata <= wd;
        #1;
        while (host_ack !== 1'b1) begin
            @(negedge clk);
            #1;
        end
        @(negedge clk);
        host_req <= 1'b0;
        @(negedge clk);
        if (!wr) begin
            check(host_rvalid, 1'b1);
            q = host_rdata;
        end
    endtask
    task automatic restart(input logic mode);
        arst_n <= 1'b0;
        eeprom_mode <= mode;
        repeat (16) @(negedge clk);
        check({config_done, ee_req, hsc}, 16'h0000);
        arst_n <= 1'b1;
        for (int n = 0; n < 3000 && config_done !== 1'b1; n++) @(negedge clk);
        check(config_done, 1'b1);
    endtask
    // =====================================================
    // main sequence
    initial begin
        void'($urandom(32'hb40a8823));
        @(negedge clk);
        restart(1'b1);
        check(vendor_code, {rom(8'h01), rom(8'h00)});
        check(product_code, {rom(8'h03), rom(8'h02)});
        check(release_number, {rom(8'h05), rom(8'h04)});
        check({cpe, m7}, {rom(`HCR_OFS_CHARGING_ENABLE), rom(`HCR_OFS_MAP_7)});
        check({upb, uppb}, {rom(8'hF6), rom(8'hF7)});
        check({lpb, pps}, {rom(8'hF8), rom(8'hFA)});
        check({m12, m34}, {rom(8'hFB), rom(8'hFC)});
        check(m56, rom(8'hFD));
        host(1'b0, `HCR_OFS_STATUS_COMMAND, 8'h00);
        check(q, 8'h00);
        host(1'b0, 8'hFE, 8'h00);
        check(q, rom(8'hFE));
        for (int i = 0; i < 24; i++) begin
            a = (i < 6) ? i[7:0] : 8'($urandom);
            d = (a == 8'hE0 || a == 8'hF5 || a == 8'hF9) ? 8'h00 : 8'($urandom);
            host(1'b1, a, d);
            host(1'b0, a, 8'h00);
            check(q, d);
            if (a == `HCR_OFS_STATUS_COMMAND) check(hsc, d);
            if (a == 8'h05) check(release_number[15:8], d);
        end
        host(1'b1, `HCR_OFS_VENDOR_HIGH, 8'h3C);
        host(1'b0, `HCR_OFS_VENDOR_HIGH, 8'h00);
        check(vendor_code[15:8], 8'h3C);
        restart(1'b0);
        check(vendor_code, 16'h0000);
        check(hsc, 8'h00);
        for (int i = 0; i < 6; i++) begin
            host(1'b0, 8'($urandom), 8'h00);
            check(q, 8'h00);
        end
        print_verdict();
    end
    initial begin
        #(20 * 20000);
        error_cnt++;
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
